// ==== common/mpm_pkg.sv ====
package mpm_pkg;
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned DEBOUNCE_US     = 10;
   localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned DB_W            = 16;
   localparam int unsigned RESET_OUT_CYC   = 16;
   localparam int unsigned NUM_DB          = 3;
   localparam int unsigned DB_PWR          = 0;
   localparam int unsigned DB_SUS          = 1;
   localparam int unsigned DB_LID          = 2;
   localparam logic [2:0]  STRAP_RESET     = 3'h7;

   typedef enum logic [2:0] {
      MPM_BOOT_CARRIER_SATA,
      MPM_BOOT_CARRIER_SD,
      MPM_BOOT_CARRIER_ESPI,
      MPM_BOOT_CARRIER_SPI,
      MPM_BOOT_MODULE_NAND,
      MPM_BOOT_REMOTE,
      MPM_BOOT_MODULE_EMMC,
      MPM_BOOT_MODULE_SPI
   } mpm_boot_t;

   typedef enum logic [1:0] {
      MPM_OFF,
      MPM_RUN,
      MPM_STANDBY
   } mpm_state_t;
endpackage

// ==== design/mpm_debounce.sv ====
`timescale 1ns/1ns
`default_nettype none
module mpm_debounce (
   input  wire logic                    clock_in,
   input  wire logic                    rst_in,
   input  wire logic                    ce_in,
   input  wire logic                    raw_n_in,
   output logic                         clean_n_out
);
   import mpm_pkg::*;
   localparam logic [DB_W-1:0] LIMIT = DB_W'(DEBOUNCE_CYC - 1);
   logic [DB_W-1:0] cnt_reg;

   // Accept new level only after it has held for the full count
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg     <= '0;
         clean_n_out <= 1'b1;
      end else if (ce_in) begin
         if (raw_n_in == clean_n_out) begin
            cnt_reg <= '0;
         end else if (cnt_reg == LIMIT) begin
            cnt_reg     <= '0;
            clean_n_out <= raw_n_in;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   a_debounce_hold: assert property (@(posedge clock_in) disable iff (rst_in)
      ($changed(clean_n_out)) |-> $past(raw_n_in) == clean_n_out)
      else $error("Debounced level changed without matching input");
   a_debounce_freeze: assert property (@(posedge clock_in) disable iff (rst_in)
      !ce_in |=> $stable(cnt_reg) && $stable(clean_n_out))
      else $error("Debouncer moved while clock enable low");
endmodule // mpm_debounce
`default_nettype wire

// ==== design/mpm_boot_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
module mpm_boot_decode (
   input  wire logic [2:0]              strap_n_in,
   output mpm_pkg::mpm_boot_t           requested_out,
   output mpm_pkg::mpm_boot_t           effective_out
);
   import mpm_pkg::*;
   logic [2:0] floating;

   // Pull-up makes a floating strap read high, i.e. deasserted
   assign floating = strap_n_in;

   always_comb begin
      unique case (floating)
         3'b000: requested_out = MPM_BOOT_CARRIER_SATA;
         3'b001: requested_out = MPM_BOOT_CARRIER_SD;
         3'b010: requested_out = MPM_BOOT_CARRIER_ESPI;
         3'b011: requested_out = MPM_BOOT_CARRIER_SPI;
         3'b100: requested_out = MPM_BOOT_MODULE_NAND;
         3'b101: requested_out = MPM_BOOT_REMOTE;
         3'b110: requested_out = MPM_BOOT_MODULE_EMMC;
         3'b111: requested_out = MPM_BOOT_MODULE_SPI;
      endcase
   end

   // Only carrier SPI is honoured; all else boots on-module SPI
   assign effective_out = (requested_out == MPM_BOOT_CARRIER_SPI) ?
                          MPM_BOOT_CARRIER_SPI : MPM_BOOT_MODULE_SPI;
endmodule // mpm_boot_decode
`default_nettype wire

// ==== design/mpm_power_mgmt.sv ====
`timescale 1ns/1ns
`default_nettype none
module mpm_power_mgmt (
   input  wire logic                    clock_in,
   input  wire logic                    rst_in,
   input  wire logic                    ce_in,
   input  wire logic                    input_supply_fault_n_in,
   input  wire logic                    carrier_reset_n_in,
   input  wire logic                    power_switch_n_in,
   input  wire logic                    suspend_request_n_in,
   input  wire logic                    cover_closed_n_in,
   input  wire logic                    battery_depleted_n_in,
   input  wire logic                    charging_n_in,
   input  wire logic                    charger_dc_present_n_in,
   input  wire logic                    test_request_n_in,
   input  wire logic                    pm_bus_alert_n_in,
   input  wire logic [2:0]              boot_strap_n_in,
   input  wire logic                    wdt_expired_in,
   input  wire logic                    pm_bus_data_in,
   input  wire logic                    pm_bus_clock_in,
   input  wire logic                    pm_bus_data_drive_low_in,
   input  wire logic                    pm_bus_clock_drive_low_in,
   output logic                         pm_bus_data_out,
   output logic                         pm_bus_data_oe_out,
   output logic                         pm_bus_clock_out,
   output logic                         pm_bus_clock_oe_out,
   output logic                         pm_bus_data_rx_out,
   output logic                         pm_bus_clock_rx_out,
   output logic                         module_supply_enable_out,
   output logic                         baseboard_supply_enable_out,
   output logic                         baseboard_standby_n_out,
   output logic                         suspend_to_ram_n_out,
   output logic                         reset_out_n_out,
   output logic                         module_reset_out,
   output logic                         watchdog_expired_n_out,
   output logic                         watchdog_expired_oe_out,
   output logic                         test_mode_out,
   output logic                         bus_alert_irq_out,
   output logic                         battery_low_out,
   output logic                         charging_out,
   output logic                         charger_present_out,
   output logic                         lid_closed_out,
   output mpm_pkg::mpm_boot_t           boot_requested_out,
   output mpm_pkg::mpm_boot_t           boot_source_out,
   output mpm_pkg::mpm_state_t          power_state_out
);
   import mpm_pkg::*;

   logic [NUM_DB-1:0]  db_raw_n;
   logic [NUM_DB-1:0]  db_clean_n;
   logic               pwr_btn_reg;
   logic               pwr_press;
   mpm_state_t         state_reg;
   mpm_state_t         state_next;
   logic [4:0]         rst_cnt_reg;
   logic               strap_taken_reg;
   logic [2:0]         strap_reg;
   mpm_boot_t          boot_req;
   mpm_boot_t          boot_eff;
   logic               supply_ok;
   logic               carrier_rst;

   assign db_raw_n[DB_PWR] = power_switch_n_in;
   assign db_raw_n[DB_SUS] = suspend_request_n_in;
   assign db_raw_n[DB_LID] = cover_closed_n_in;

   // One debouncer each for power switch, suspend request and cover closed
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DB; gi++) begin : g_db
         mpm_debounce u_db (
            .clock_in    (clock_in),
            .rst_in      (rst_in),
            .ce_in       (ce_in),
            .raw_n_in    (db_raw_n[gi]),
            .clean_n_out (db_clean_n[gi])
         );
      end
   endgenerate

   assign supply_ok   = input_supply_fault_n_in;
   assign carrier_rst = ~carrier_reset_n_in;

   // Press edge of debounced power switch
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pwr_btn_reg <= 1'b0;
      end else if (ce_in) begin
         pwr_btn_reg <= ~db_clean_n[DB_PWR];
      end
   end
   assign pwr_press = ~db_clean_n[DB_PWR] & ~pwr_btn_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         MPM_OFF: begin
            if (pwr_press) begin
               state_next = MPM_RUN;
            end
         end
         MPM_RUN: begin
            if (pwr_press) begin
               state_next = MPM_OFF;
            end else if (~db_clean_n[DB_SUS] | ~db_clean_n[DB_LID]) begin
               state_next = MPM_STANDBY;
            end
         end
         MPM_STANDBY: begin
            if (pwr_press) begin
               state_next = MPM_RUN;
            end
         end
         default: state_next = MPM_OFF;
      endcase
      if (!supply_ok) begin
         state_next = MPM_OFF;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= MPM_OFF;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   // Reset pulse: carrier reset stretches, module reset follows
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rst_cnt_reg <= 5'(RESET_OUT_CYC);
      end else if (ce_in) begin
         if (carrier_rst) begin
            rst_cnt_reg <= 5'(RESET_OUT_CYC);
         end else if (rst_cnt_reg != '0) begin
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
         end
      end
   end
   assign module_reset_out = carrier_rst | (rst_cnt_reg != '0);

   // Straps captured once after reset release
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         strap_taken_reg <= 1'b0;
         strap_reg       <= STRAP_RESET;
      end else if (ce_in && !strap_taken_reg) begin
         strap_taken_reg <= 1'b1;
         strap_reg       <= boot_strap_n_in;
      end
   end

   mpm_boot_decode u_boot (
      .strap_n_in    (strap_reg),
      .requested_out (boot_req),
      .effective_out (boot_eff)
   );

   // Registered status and control outputs
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         module_supply_enable_out    <= 1'b0;
         baseboard_supply_enable_out <= 1'b0;
         suspend_to_ram_n_out        <= 1'b0;
         baseboard_standby_n_out     <= 1'b0;
         reset_out_n_out             <= 1'b0;
         watchdog_expired_n_out      <= 1'b1;
         watchdog_expired_oe_out     <= 1'b0;
         test_mode_out               <= 1'b0;
         bus_alert_irq_out           <= 1'b0;
         battery_low_out             <= 1'b0;
         charging_out                <= 1'b0;
         charger_present_out         <= 1'b0;
         lid_closed_out              <= 1'b0;
         boot_requested_out          <= MPM_BOOT_MODULE_SPI;
         boot_source_out             <= MPM_BOOT_MODULE_SPI;
      end else if (ce_in) begin
         module_supply_enable_out    <= supply_ok & (state_next != MPM_OFF);
         baseboard_supply_enable_out <= supply_ok & (state_next == MPM_RUN);
         suspend_to_ram_n_out        <= (state_next == MPM_RUN);
         baseboard_standby_n_out     <= (state_next == MPM_RUN);
         reset_out_n_out             <= ~module_reset_out & (state_reg == MPM_RUN);
         watchdog_expired_n_out      <= ~wdt_expired_in;
         watchdog_expired_oe_out     <= (state_next == MPM_RUN);
         test_mode_out               <= ~test_request_n_in;
         bus_alert_irq_out           <= ~pm_bus_alert_n_in;
         battery_low_out             <= ~battery_depleted_n_in;
         charging_out                <= ~charging_n_in;
         charger_present_out         <= ~charger_dc_present_n_in;
         lid_closed_out              <= ~db_clean_n[DB_LID];
         boot_requested_out          <= boot_req;
         boot_source_out             <= boot_eff;
      end
   end

   assign power_state_out = state_reg;

   // Open-drain two-wire bus: drive low only
   assign pm_bus_data_out     = 1'b0;
   assign pm_bus_clock_out    = 1'b0;
   assign pm_bus_data_oe_out  = pm_bus_data_drive_low_in;
   assign pm_bus_clock_oe_out = pm_bus_clock_drive_low_in;
   assign pm_bus_data_rx_out  = pm_bus_data_in;
   assign pm_bus_clock_rx_out = pm_bus_clock_in;

   a_fault_kills_supply: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && !input_supply_fault_n_in) |=> !baseboard_supply_enable_out
         && !module_supply_enable_out)
      else $error("Supply enabled during input supply fault");
   a_carrier_after_run: assert property (@(posedge clock_in) disable iff (rst_in)
      baseboard_supply_enable_out |-> module_supply_enable_out)
      else $error("Carrier powered without module supply");
   a_standby_follows: assert property (@(posedge clock_in) disable iff (rst_in)
      baseboard_standby_n_out == suspend_to_ram_n_out)
      else $error("Standby output does not follow suspend state");
   a_standby_low: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && state_reg == MPM_STANDBY && state_next == MPM_STANDBY)
         |=> !baseboard_standby_n_out)
      else $error("Standby output high in standby state");
   a_reset_out_low: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && module_reset_out) |=> !reset_out_n_out)
      else $error("Reset output released during module reset");
   a_carrier_reset: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && !carrier_reset_n_in) |=> module_reset_out [*2])
      else $error("Carrier reset did not hold module reset");
   a_wdt_runtime: assert property (@(posedge clock_in) disable iff (rst_in)
      watchdog_expired_oe_out |-> state_reg == MPM_RUN)
      else $error("Watchdog output driven outside runtime");
   a_alert_irq: assert property (@(posedge clock_in) disable iff (rst_in)
      ce_in |=> bus_alert_irq_out == !$past(pm_bus_alert_n_in))
      else $error("Alert interrupt mismatch");
   a_test_mode: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && !test_request_n_in) |=> test_mode_out)
      else $error("Test mode not entered");
   a_strap_held: assert property (@(posedge clock_in) disable iff (rst_in)
      strap_taken_reg |=> $stable(strap_reg))
      else $error("Boot strap changed after capture");
   a_boot_fallback: assert property (@(posedge clock_in) disable iff (rst_in)
      (boot_source_out == MPM_BOOT_CARRIER_SPI) || (boot_source_out == MPM_BOOT_MODULE_SPI))
      else $error("Unsupported boot source selected");

   // State machine, reset counter, pin status and boot strap checks
   a_press_to_run: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && supply_ok && state_reg == MPM_OFF && pwr_press)
         |=> state_reg == MPM_RUN)
      else $error("Power press did not start runtime");
   a_sleep_entry: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && supply_ok && state_reg == MPM_RUN && !pwr_press
         && (!db_clean_n[DB_SUS] || !db_clean_n[DB_LID])) |=> state_reg == MPM_STANDBY)
      else $error("Sleep request did not enter standby");
   a_fault_forces_off: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && !supply_ok) |=> state_reg == MPM_OFF)
      else $error("Supply fault did not force off state");
   a_supply_needs_state: assert property (@(posedge clock_in) disable iff (rst_in)
      module_supply_enable_out |-> state_reg != MPM_OFF)
      else $error("Module supply enabled in off state");
   a_module_reset_level: assert property (@(posedge clock_in) disable iff (rst_in)
      !carrier_reset_n_in |-> module_reset_out)
      else $error("Module reset low while carrier reset held");
   a_reset_count_down: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && carrier_reset_n_in && rst_cnt_reg != 5'h0)
         |=> rst_cnt_reg == $past(rst_cnt_reg) - 5'h1)
      else $error("Reset stretch counter did not count down");
   a_reset_release: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && carrier_reset_n_in && rst_cnt_reg == 5'h1)
         |=> module_reset_out == !carrier_reset_n_in)
      else $error("Module reset not released after stretch");
   a_reset_out_run: assert property (@(posedge clock_in) disable iff (rst_in)
      (reset_out_n_out && $past(ce_in))
         |-> $past(state_reg) == MPM_RUN)
      else $error("Reset output released outside runtime");
   a_standby_not_run: assert property (@(posedge clock_in) disable iff (rst_in)
      !baseboard_standby_n_out |-> state_reg != MPM_RUN)
      else $error("Standby output low in runtime");
   a_wdt_level: assert property (@(posedge clock_in) disable iff (rst_in)
      ce_in |=> watchdog_expired_n_out == !$past(wdt_expired_in))
      else $error("Watchdog output level mismatch");
   a_battery_status: assert property (@(posedge clock_in) disable iff (rst_in)
      ce_in |=> battery_low_out == !$past(battery_depleted_n_in))
      else $error("Battery low status mismatch");
   a_charging_status: assert property (@(posedge clock_in) disable iff (rst_in)
      ce_in |=> charging_out == !$past(charging_n_in))
      else $error("Charging status mismatch");
   a_charger_status: assert property (@(posedge clock_in) disable iff (rst_in)
      ce_in |=> charger_present_out == !$past(charger_dc_present_n_in))
      else $error("Charger present status mismatch");
   a_lid_status: assert property (@(posedge clock_in) disable iff (rst_in)
      ce_in |=> lid_closed_out == !$past(db_clean_n[DB_LID]))
      else $error("Lid status mismatch");
   a_bus_drive_low: assert property (@(posedge clock_in) disable iff (rst_in)
      !pm_bus_data_out && !pm_bus_clock_out && pm_bus_data_oe_out == pm_bus_data_drive_low_in
         && pm_bus_clock_oe_out == pm_bus_clock_drive_low_in)
      else $error("Two-wire bus driven other than low");
   a_bus_sense: assert property (@(posedge clock_in) disable iff (rst_in)
      pm_bus_data_rx_out == pm_bus_data_in && pm_bus_clock_rx_out == pm_bus_clock_in)
      else $error("Two-wire bus sense mismatch");
   a_strap_capture: assert property (@(posedge clock_in) disable iff (rst_in)
      (ce_in && !strap_taken_reg) |=> strap_reg == $past(boot_strap_n_in))
      else $error("Boot straps not captured at first edge");
   a_boot_honoured: assert property (@(posedge clock_in) disable iff (rst_in)
      boot_source_out == MPM_BOOT_CARRIER_SPI |-> boot_requested_out == MPM_BOOT_CARRIER_SPI)
      else $error("Carrier boot honoured for wrong strap setting");
endmodule // mpm_power_mgmt
`default_nettype wire

// ==== dv/mpm_carrier_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module mpm_carrier_model (
   input  wire logic [9:0] pull_in,
   input  wire logic [2:0] strap_gnd_in,
   input  wire logic       supply_enable_in,
   input  wire logic       data_oe_in,
   input  wire logic       clock_oe_in,
   input  wire logic       data_low_in,
   input  wire logic       clock_low_in,
   output logic      [9:0] line_n_out,
   output logic      [2:0] strap_n_out,
   output logic            data_wire_out,
   output logic            clock_wire_out,
   output logic            rail_on_out
);
   // Open-drain lines with pull-ups: released reads high
   assign line_n_out[5:0] = ~pull_in[5:0];
   assign line_n_out[6]   = ~pull_in[6];
   assign line_n_out[7]   = ~pull_in[7];
   assign line_n_out[9:8] = ~pull_in[9:8];
   assign strap_n_out     = ~strap_gnd_in;
   assign data_wire_out   = ~(data_oe_in | data_low_in);
   assign clock_wire_out  = ~(clock_oe_in | clock_low_in);
   // Ordinary carrier circuits sit behind the baseboard supply enable
   assign rail_on_out     = supply_enable_in;
endmodule // mpm_carrier_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mpm_pkg::*;
   logic       clock_in, rst_in, ce_in, wdt_expired_in, cd_low, cc_low, rail;
   logic       pm_bus_data_drive_low_in, pm_bus_clock_drive_low_in;
   logic [9:0] pull, ln;
   logic [2:0] strap_gnd, boot_strap_n_in;
   logic       pm_bus_data_in, pm_bus_clock_in, pm_bus_data_out, pm_bus_data_oe_out;
   logic       pm_bus_clock_out, pm_bus_clock_oe_out, pm_bus_data_rx_out, pm_bus_clock_rx_out;
   logic       module_supply_enable_out, baseboard_supply_enable_out, baseboard_standby_n_out;
   logic       suspend_to_ram_n_out, reset_out_n_out, module_reset_out;
   logic       watchdog_expired_n_out, watchdog_expired_oe_out, test_mode_out;
   logic       bus_alert_irq_out, battery_low_out, charging_out, charger_present_out;
   logic       lid_closed_out;
   mpm_boot_t  boot_requested_out, boot_source_out;
   mpm_state_t power_state_out;
   int         fails, cmp_count;

   mpm_carrier_model u_mpm_carrier_model (.pull_in(pull), .strap_gnd_in(strap_gnd),
      .supply_enable_in(baseboard_supply_enable_out), .data_oe_in(pm_bus_data_oe_out),
      .clock_oe_in(pm_bus_clock_oe_out), .data_low_in(cd_low), .clock_low_in(cc_low),
      .line_n_out(ln), .strap_n_out(boot_strap_n_in), .data_wire_out(pm_bus_data_in),
      .clock_wire_out(pm_bus_clock_in), .rail_on_out(rail));

   mpm_power_mgmt u_mpm_power_mgmt (.clock_in, .rst_in, .ce_in,
      .input_supply_fault_n_in(ln[0]), .carrier_reset_n_in(ln[1]), .power_switch_n_in(ln[2]),
      .suspend_request_n_in(ln[3]), .cover_closed_n_in(ln[4]), .battery_depleted_n_in(ln[5]),
      .charging_n_in(ln[6]), .charger_dc_present_n_in(ln[7]), .test_request_n_in(ln[8]),
      .pm_bus_alert_n_in(ln[9]), .boot_strap_n_in, .wdt_expired_in, .pm_bus_data_in,
      .pm_bus_clock_in, .pm_bus_data_drive_low_in, .pm_bus_clock_drive_low_in,
      .pm_bus_data_out, .pm_bus_data_oe_out, .pm_bus_clock_out, .pm_bus_clock_oe_out,
      .pm_bus_data_rx_out, .pm_bus_clock_rx_out, .module_supply_enable_out,
      .baseboard_supply_enable_out, .baseboard_standby_n_out, .suspend_to_ram_n_out,
      .reset_out_n_out, .module_reset_out, .watchdog_expired_n_out, .watchdog_expired_oe_out,
      .test_mode_out, .bus_alert_irq_out, .battery_low_out, .charging_out,
      .charger_present_out, .lid_closed_out, .boot_requested_out, .boot_source_out,
      .power_state_out);

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #2;
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Debounced press: held long enough, then released long enough
   task automatic press(input int idx);
      pull[idx] = 1'b1;
      step(510);
      pull[idx] = 1'b0;
      step(510);
   endtask

   task automatic t_reset;
      step(19);
      check(8'({module_reset_out, watchdog_expired_n_out, watchdog_expired_oe_out}),
            8'h06);
      check(8'(boot_source_out), 8'h07);
      step(1);
      rst_in = 1'b0;
      step(10);
      check(8'(module_reset_out), 8'h01);
      step(10);
      check(8'(module_reset_out), 8'h00);
      check(8'({power_state_out, baseboard_supply_enable_out, reset_out_n_out}),
            8'h00);
   endtask

   task automatic t_boot;
      for (int s = 0; s < 8; s++) begin
         strap_gnd = ~s[2:0];
         rst_in = 1'b1;
         step(2);
         rst_in = 1'b0;
         step(1);
         strap_gnd = s[2:0];
         step(3);
         check(8'(boot_requested_out), 8'(s));
         check(8'(boot_source_out), (s == 3) ? 8'h03 : 8'h07);
      end
      strap_gnd = 3'h0;
      rst_in = 1'b1;
      step(2);
      rst_in = 1'b0;
      step(20);
   endtask

   task automatic t_power;
      press(2);
      check(8'(power_state_out), 8'h01);
      check(8'({rail, module_supply_enable_out, baseboard_standby_n_out}), 8'h07);
      check(8'({reset_out_n_out, watchdog_expired_oe_out}), 8'h03);
      wdt_expired_in = 1'b1;
      step(2);
      check(8'(watchdog_expired_n_out), 8'h00);
      wdt_expired_in = 1'b0;
      pull[2] = 1'b1;
      step(100);
      pull[2] = 1'b0;
      step(600);
      check(8'(power_state_out), 8'h01);
      pull[3] = 1'b1;
      step(510);
      check(8'(power_state_out), 8'h02);
      check(8'({baseboard_standby_n_out, suspend_to_ram_n_out}), 8'h00);
      check(8'({baseboard_supply_enable_out, watchdog_expired_oe_out}), 8'h00);
      pull[3] = 1'b0;
      step(510);
      press(2);
      check(8'(power_state_out), 8'h01);
      pull[4] = 1'b1;
      step(510);
      check(8'({lid_closed_out, power_state_out}), 8'h06);
      pull[4] = 1'b0;
      step(510);
      press(2);
      pull[1] = 1'b1;
      step(3);
      check(8'({module_reset_out, reset_out_n_out}), 8'h02);
      pull[1] = 1'b0;
      step(10);
      check(8'(module_reset_out), 8'h01);
      step(10);
      check(8'(module_reset_out), 8'h00);
   endtask

   task automatic t_fault_levels;
      pull[0] = 1'b1;
      step(3);
      press(2);
      check(8'({module_supply_enable_out, baseboard_supply_enable_out}), 8'h00);
      check(8'(power_state_out), 8'h00);
      pull[0] = 1'b0;
      for (int i = 5; i < 10; i++) begin
         pull[i] = 1'b1;
         step(3);
         check(8'({bus_alert_irq_out, test_mode_out, charger_present_out, charging_out,
                   battery_low_out}), 8'(1 << (i - 5)));
         pull[i] = 1'b0;
      end
      ce_in = 1'b0;
      pull[5] = 1'b1;
      step(3);
      check(8'(battery_low_out), 8'h00);
      ce_in = 1'b1;
      step(3);
      check(8'(battery_low_out), 8'h01);
      pull[5] = 1'b0;
      for (int k = 0; k < 4; k++) begin
         {pm_bus_data_drive_low_in, cd_low} = k[1:0];
         {pm_bus_clock_drive_low_in, cc_low} = k[1:0];
         step(1);
         check(8'({pm_bus_data_oe_out, pm_bus_data_out, pm_bus_data_rx_out, pm_bus_clock_oe_out,
                   pm_bus_clock_out, pm_bus_clock_rx_out}),
               8'({2{k[1], 1'b0, ~(k[1] | k[0])}}));
      end
   endtask

   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      wdt_expired_in = 1'b0;
      pull = 10'h000;
      strap_gnd = 3'h0;
      cd_low = 1'b0;
      cc_low = 1'b0;
      pm_bus_data_drive_low_in = 1'b0;
      pm_bus_clock_drive_low_in = 1'b0;
      fails = 0;
      cmp_count = 0;
      #2;
      t_reset();
      t_boot();
      t_power();
      t_fault_levels();
      wrap_up();
   end

   // Cuts a hang short well beyond the expected run length
   initial begin
      #1_000_000;
      fails++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
